// file: core/duart_register_decode_loopback.sv
// per-channel register decoder and internal loopback path of a dual uart
`timescale 1ns/100ps
`default_nettype none

module duart_register_decode_loopback
  import duart_regs_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h0011, // arbitrary value
  parameter logic [7:0] IDENT_CODE    = 8'h005A  // arbitrary value
) (
  // clock and reset
  input  wire  logic       clk,
  input  wire  logic       reset_n,
  // host bus pins
  input  wire  host_bus_t  host_pins,
  output logic [7:0]       host_rdata,
  output logic             host_rdata_oe,
  // serial pins
  input  wire  serial_in_t line_pins    [NUM_CH],
  output logic [NUM_CH-1:0] tx_pin,
  output logic [NUM_CH-1:0] rts_n_pin,
  output logic [NUM_CH-1:0] dtr_n_pin,
  // channel core side
  input  wire  logic [NUM_CH-1:0] tx_shift_out,
  input  wire  chan_stat_t stat         [NUM_CH],
  output serial_in_t       core_in      [NUM_CH],
  output chan_cfg_t        cfg          [NUM_CH],
  output chan_evt_t        evt          [NUM_CH]
);

  // channel registers, one element per channel
  logic [7:0] line_control       [NUM_CH];
  logic [7:0] modem_control      [NUM_CH];
  logic [7:0] interrupt_enable   [NUM_CH];
  logic [7:0] enhanced_function  [NUM_CH];
  logic [7:0] divisor_low_byte   [NUM_CH];
  logic [7:0] divisor_high_byte  [NUM_CH];
  logic [7:0] divisor_fraction   [NUM_CH];
  logic [7:0] resume_char_first  [NUM_CH];
  logic [7:0] resume_char_second [NUM_CH];
  logic [7:0] pause_char_first   [NUM_CH];
  logic [7:0] pause_char_second  [NUM_CH];
  logic [7:0] scratch_byte       [NUM_CH];

  logic [NUM_CH-1:0] key_on;
  logic [NUM_CH-1:0] div_on;
  logic [NUM_CH-1:0] enh_on;
  logic [NUM_CH-1:0] div_zero;
  logic [NUM_CH-1:0] loop_on;

  // bus pin synchroniser: three stages, a bit moves once stages two and three agree
  logic [14:0] bus_s1;
  logic [14:0] bus_s2;
  logic [14:0] bus_s3;
  host_bus_t   bus_q;
  logic [14:0] bus_agree;

  assign bus_agree = ~(bus_s2 ^ bus_s3);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_s1 <= BUS_IDLE;
      bus_s2 <= BUS_IDLE;
      bus_s3 <= BUS_IDLE;
      bus_q  <= BUS_IDLE;
    end else begin
      bus_s1 <= host_pins;
      bus_s2 <= bus_s1;
      bus_s3 <= bus_s2;
      bus_q  <= host_bus_t'((bus_s3 & bus_agree) | (bus_q & ~bus_agree));
    end
  end

  // channel pick: exactly one select low, both low is refused
  logic sel_valid;
  logic sel_ch;
  logic rd_act;
  logic wr_act;
  logic rd_prev;
  logic wr_prev;
  logic rd_start;
  logic wr_commit;

  assign sel_valid = bus_q.sel_a_n ^ bus_q.sel_b_n;
  assign sel_ch    = bus_q.sel_a_n;
  assign rd_act    = sel_valid & ~bus_q.rd_n;
  assign wr_act    = sel_valid & ~bus_q.wr_n;
  assign rd_start  = rd_act & ~rd_prev;
  assign wr_commit = wr_prev & ~wr_act;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
    end else begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
    end
  end

  // write operands are captured while the strobe is low so the release edge cannot race them
  logic       wr_ch;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ch   <= 1'b0;
      wr_addr <= ADDR_HOLDING;
      wr_data <= REG_RESET;
    end else if (wr_act) begin
      wr_ch   <= sel_ch;
      wr_addr <= bus_q.addr;
      wr_data <= bus_q.wdata;
    end
  end

  // read mux for the selected channel
  logic [7:0] next_rdata;
  logic       rd_is_rx;
  logic       rd_is_istat;
  logic       rd_is_lstat;
  logic       rd_is_mstat;
  logic       rch;

  assign rch = sel_ch;

  always_comb begin
    next_rdata = WO_READ_VALUE;
    rd_is_rx   = 1'b0;
    rd_is_istat = 1'b0;
    rd_is_lstat = 1'b0;
    rd_is_mstat = 1'b0;
    case (bus_q.addr)
      ADDR_HOLDING: begin
        if (!line_control[rch][LINE_DIV_BIT]) begin
          next_rdata = stat[rch].rx_char;
          rd_is_rx   = 1'b1;
        end else if (!key_on[rch] && div_zero[rch]) begin
          next_rdata = REVISION_CODE;
        end else begin
          next_rdata = divisor_low_byte[rch];
        end
      end
      ADDR_IE: begin
        if (!line_control[rch][LINE_DIV_BIT]) begin
          next_rdata = interrupt_enable[rch];
        end else if (!key_on[rch] && div_zero[rch]) begin
          next_rdata = IDENT_CODE;
        end else begin
          next_rdata = divisor_high_byte[rch];
        end
      end
      ADDR_STATUS: begin
        if (key_on[rch]) begin
          next_rdata = enhanced_function[rch];
        end else if (div_on[rch] && enh_on[rch]) begin
          next_rdata = divisor_fraction[rch] & FRACTION_MASK;
        end else begin
          next_rdata = enh_on[rch] ? stat[rch].istat
                                   : (stat[rch].istat & ~ISTAT_ENH_MASK);
          rd_is_istat = 1'b1;
        end
      end
      ADDR_LINE: begin
        next_rdata = line_control[rch];
      end
      ADDR_MODEM: begin
        next_rdata = key_on[rch] ? resume_char_first[rch]
                                 : modem_control[rch];
      end
      ADDR_LSTAT: begin
        next_rdata = key_on[rch] ? resume_char_second[rch]
                                 : stat[rch].lstat;
        rd_is_lstat = ~key_on[rch];
      end
      ADDR_MSTAT: begin
        next_rdata = key_on[rch] ? pause_char_first[rch] : stat[rch].mstat;
        rd_is_mstat = ~key_on[rch];
      end
      default: begin
        next_rdata = key_on[rch] ? pause_char_second[rch]
                                 : scratch_byte[rch];
      end
    endcase
  end

  // read data is frozen at strobe start so side-effect reads return a stable byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_rdata <= REG_RESET;
    end else if (rd_start) begin
      host_rdata <= next_rdata;
    end
  end

  assign host_rdata_oe = rd_act & rd_prev;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      logic       wr_here;
      logic       rd_here;
      serial_in_t line_s1;
      serial_in_t line_s2;
      serial_in_t line_s3;
      serial_in_t line_q;
      logic [4:0] line_agree;

      assign wr_here     = wr_commit & (wr_ch == 1'(ch));
      assign rd_here     = rd_start & (rch == 1'(ch));
      assign key_on[ch]  = (line_control[ch] == LINE_KEY);
      assign div_on[ch]  = line_control[ch][LINE_DIV_BIT] & ~key_on[ch];
      assign enh_on[ch]  = enhanced_function[ch][ENH_ON_BIT];
      assign div_zero[ch] = (divisor_low_byte[ch] == DIV_ZERO) &&
                            (divisor_high_byte[ch] == DIV_ZERO);
      assign loop_on[ch] = modem_control[ch][MODEM_LOOP_BIT];

      // register writes; decode uses the state from before this write
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          line_control[ch]       <= REG_RESET;
          modem_control[ch]      <= REG_RESET;
          interrupt_enable[ch]   <= REG_RESET;
          enhanced_function[ch]  <= REG_RESET;
          divisor_low_byte[ch]   <= REG_RESET;
          divisor_high_byte[ch]  <= REG_RESET;
          divisor_fraction[ch]   <= REG_RESET;
          resume_char_first[ch]  <= REG_RESET;
          resume_char_second[ch] <= REG_RESET;
          pause_char_first[ch]   <= REG_RESET;
          pause_char_second[ch]  <= REG_RESET;
          scratch_byte[ch]       <= REG_RESET;
        end else if (wr_here) begin
          case (wr_addr)
            ADDR_HOLDING: begin
              if (line_control[ch][LINE_DIV_BIT]) begin
                divisor_low_byte[ch] <= wr_data;
              end
            end
            ADDR_IE: begin
              if (line_control[ch][LINE_DIV_BIT]) begin
                divisor_high_byte[ch] <= wr_data;
              end else if (enh_on[ch]) begin
                interrupt_enable[ch] <= wr_data;
              end else begin
                interrupt_enable[ch] <= (interrupt_enable[ch] & IE_ENH_MASK) |
                                        (wr_data & ~IE_ENH_MASK);
              end
            end
            ADDR_STATUS: begin
              if (key_on[ch]) begin
                enhanced_function[ch] <= wr_data;
              end else if (div_on[ch] && enh_on[ch]) begin
                divisor_fraction[ch] <= wr_data & FRACTION_MASK;
              end
            end
            ADDR_LINE: begin
              line_control[ch] <= wr_data;
            end
            ADDR_MODEM: begin
              if (key_on[ch]) begin
                resume_char_first[ch] <= wr_data;
              end else if (enh_on[ch]) begin
                modem_control[ch] <= wr_data;
              end else begin
                modem_control[ch] <= (modem_control[ch] & MODEM_ENH_MASK) |
                                     (wr_data & ~MODEM_ENH_MASK);
              end
            end
            ADDR_LSTAT: begin
              if (key_on[ch]) begin
                resume_char_second[ch] <= wr_data;
              end
            end
            ADDR_MSTAT: begin
              if (key_on[ch]) begin
                pause_char_first[ch] <= wr_data;
              end
            end
            default: begin
              if (key_on[ch]) begin
                pause_char_second[ch] <= wr_data;
              end else begin
                scratch_byte[ch] <= wr_data;
              end
            end
          endcase
        end
      end

      // one-cycle events to the channel core; line and modem status writes raise no load pulse, only the data byte follows them
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          evt[ch] <= '0;
        end else begin
          evt[ch].tx_load    <= wr_here && (wr_addr == ADDR_HOLDING) &&
                                !line_control[ch][LINE_DIV_BIT];
          evt[ch].fifo_load  <= wr_here && (wr_addr == ADDR_STATUS) &&
                                !key_on[ch] && !(div_on[ch] && enh_on[ch]);
          evt[ch].rx_read    <= rd_here & rd_is_rx;
          evt[ch].istat_read <= rd_here & rd_is_istat;
          evt[ch].lstat_read <= rd_here & rd_is_lstat;
          evt[ch].mstat_read <= rd_here & rd_is_mstat;
          // only fifo control carries extended bits; a transmit byte must pass whole
          if (wr_here && (wr_addr == ADDR_STATUS) && !enh_on[ch]) begin
            evt[ch].data <= wr_data & ~FIFO_ENH_MASK;
          end else if (wr_here) begin
            evt[ch].data <= wr_data;
          end
        end
      end

      // modem and receive pins: three stages, move once stages two and three agree
      assign line_agree = ~(line_s2 ^ line_s3);

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          line_s1 <= LINE_IDLE;
          line_s2 <= LINE_IDLE;
          line_s3 <= LINE_IDLE;
          line_q  <= LINE_IDLE;
        end else begin
          line_s1 <= line_pins[ch];
          line_s2 <= line_s1;
          line_s3 <= line_s2;
          line_q  <= serial_in_t'((line_s3 & line_agree) | (line_q & ~line_agree));
        end
      end

      // pins freeze on loopback entry so the far end sees no diagnostic traffic
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          tx_pin[ch]    <= 1'b1;
          rts_n_pin[ch] <= 1'b1;
          dtr_n_pin[ch] <= 1'b1;
        end else if (!loop_on[ch]) begin
          tx_pin[ch]    <= tx_shift_out[ch];
          rts_n_pin[ch] <= ~modem_control[ch][MODEM_RTS_BIT];
          dtr_n_pin[ch] <= ~modem_control[ch][MODEM_DTR_BIT];
        end
      end

      always_comb begin
        if (loop_on[ch]) begin
          core_in[ch]    = LINE_IDLE;
          core_in[ch].rx = tx_shift_out[ch];
        end else begin
          core_in[ch]    = line_q;
        end
      end

      // configuration view; extended modem, interrupt-enable and fraction fields show only with the enhanced bit
      always_comb begin
        cfg[ch].line_ctl    = line_control[ch];
        cfg[ch].modem_ctl   = enh_on[ch] ? modem_control[ch]
                                         : (modem_control[ch] & ~MODEM_ENH_MASK);
        cfg[ch].int_enable  = enh_on[ch] ? interrupt_enable[ch]
                                         : (interrupt_enable[ch] & ~IE_ENH_MASK);
        cfg[ch].enh_func    = enhanced_function[ch];
        cfg[ch].div_low     = divisor_low_byte[ch];
        cfg[ch].div_high    = divisor_high_byte[ch];
        cfg[ch].div_frac    = enh_on[ch] ? divisor_fraction[ch] : REG_RESET;
        cfg[ch].xon1        = resume_char_first[ch];
        cfg[ch].xon2        = resume_char_second[ch];
        cfg[ch].xoff1       = pause_char_first[ch];
        cfg[ch].xoff2       = pause_char_second[ch];
        cfg[ch].loopback    = loop_on[ch];
        cfg[ch].auto_rts_en = enhanced_function[ch][ENH_ARTS_BIT] & ~loop_on[ch];
        cfg[ch].auto_cts_en = enhanced_function[ch][ENH_ACTS_BIT] & ~loop_on[ch];
      end
    end
  endgenerate

endmodule : duart_register_decode_loopback

`default_nettype wire

// file: pkg/duart_regs_pkg.sv
// constants, field layout and carrier types of the dual-channel register decoder
package duart_regs_pkg;

  localparam int NUM_CH = 2;

  // register offsets on the three address lines
  localparam logic [2:0] ADDR_HOLDING = 3'h0;
  localparam logic [2:0] ADDR_IE      = 3'h1;
  localparam logic [2:0] ADDR_STATUS  = 3'h2;
  localparam logic [2:0] ADDR_LINE    = 3'h3;
  localparam logic [2:0] ADDR_MODEM   = 3'h4;
  localparam logic [2:0] ADDR_LSTAT   = 3'h5;
  localparam logic [2:0] ADDR_MSTAT   = 3'h6;
  localparam logic [2:0] ADDR_SCRATCH = 3'h7;

  // field positions and keys
  localparam logic [7:0] LINE_KEY       = 8'h00BF;
  localparam int         LINE_DIV_BIT   = 7;
  localparam int         MODEM_LOOP_BIT = 4;
  localparam int         MODEM_RTS_BIT  = 1;
  localparam int         MODEM_DTR_BIT  = 0;
  localparam int         ENH_ON_BIT     = 4;
  localparam int         ENH_ARTS_BIT   = 6;
  localparam int         ENH_ACTS_BIT   = 7;
  localparam logic [7:0] IE_ENH_MASK    = 8'h00F0;
  localparam logic [7:0] MODEM_ENH_MASK = 8'h00E0;
  localparam logic [7:0] FIFO_ENH_MASK  = 8'h0030;
  localparam logic [7:0] ISTAT_ENH_MASK = 8'h0030;
  localparam logic [7:0] FRACTION_MASK  = 8'h003F;
  localparam logic [7:0] DIV_ZERO      = 8'h0000;

  // reset and idle values
  localparam logic [7:0] REG_RESET     = 8'h0000;
  localparam logic [7:0] WO_READ_VALUE = 8'h0000;

  typedef struct packed {
    logic       sel_a_n;
    logic       sel_b_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_bus_t;

  localparam host_bus_t BUS_IDLE = 15'h7800;

  typedef struct packed {
    logic rx;
    logic cts_n;
    logic dsr_n;
    logic cd_n;
    logic ri_n;
  } serial_in_t;

  localparam serial_in_t LINE_IDLE = 5'h1F;

  typedef struct packed {
    logic [7:0] rx_char;
    logic [7:0] istat;
    logic [7:0] lstat;
    logic [7:0] mstat;
  } chan_stat_t;

  typedef struct packed {
    logic       tx_load;
    logic       fifo_load;
    logic       rx_read;
    logic       istat_read;
    logic       lstat_read;
    logic       mstat_read;
    logic [7:0] data;
  } chan_evt_t;

  typedef struct packed {
    logic [7:0] line_ctl;
    logic [7:0] modem_ctl;
    logic [7:0] int_enable;
    logic [7:0] enh_func;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] div_frac;
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
    logic       loopback;
    logic       auto_rts_en;
    logic       auto_cts_en;
  } chan_cfg_t;

endpackage : duart_regs_pkg

// file: verification/duart_decode_sva.sv
// assertions on the decoder's pins, configuration view and loopback routing
`timescale 1ns/100ps
`default_nettype none

module duart_decode_sva
  import duart_regs_pkg::*;
(
  // clock and reset
  input wire logic              clk,
  input wire logic              reset_n,
  // host side
  input wire host_bus_t         host_pins,
  input wire logic [7:0]        host_rdata,
  input wire logic              host_rdata_oe,
  // serial and core side
  input wire logic [NUM_CH-1:0] tx_pin,
  input wire logic [NUM_CH-1:0] rts_n_pin,
  input wire logic [NUM_CH-1:0] tx_shift_out,
  input wire serial_in_t        core_in [NUM_CH],
  input wire chan_cfg_t         cfg     [NUM_CH],
  input wire chan_evt_t         evt     [NUM_CH]
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence both_selected;
    !host_pins.sel_a_n && !host_pins.sel_b_n;
  endsequence

  a_read_data_held: assert property (
    host_rdata_oe && $past(host_rdata_oe) |-> $stable(host_rdata))
    else $error("read byte moved while driven");
  // selects are filtered, so give the filter time before judging
  a_dual_select_void: assert property (
    both_selected [*8] |-> !host_rdata_oe)
    else $error("read answered with both channels selected");

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    a_loop_bit_map: assert property (
      cfg[c].loopback == cfg[c].modem_ctl[MODEM_LOOP_BIT])
      else $error("loopback flag differs from modem control bit");
    a_loop_rx_route: assert property (
      cfg[c].loopback |-> core_in[c].rx == tx_shift_out[c])
      else $error("loopback receive input not fed from transmitter");
    a_loop_modem_idle: assert property (
      cfg[c].loopback |-> core_in[c][3:0] == 4'h0F)
      else $error("modem inputs not ignored in loopback");
    a_loop_pins_hold: assert property (
      cfg[c].loopback && $past(cfg[c].loopback) |-> $stable(tx_pin[c]) && $stable(rts_n_pin[c]))
      else $error("serial output pins moved in loopback");
    a_tx_follow_core: assert property (
      !$past(cfg[c].loopback) |-> tx_pin[c] == $past(tx_shift_out[c]))
      else $error("transmit pin not one cycle behind shifter");
    a_rts_from_ctrl: assert property (
      !cfg[c].loopback && !$past(cfg[c].loopback) && $stable(cfg[c].modem_ctl)
      |-> rts_n_pin[c] == !cfg[c].modem_ctl[MODEM_RTS_BIT])
      else $error("request-to-send pin disagrees with modem control");
    a_loop_no_auto: assert property (
      cfg[c].loopback |-> !cfg[c].auto_rts_en && !cfg[c].auto_cts_en)
      else $error("automatic flow control left on in loopback");
    a_ext_bits_gated: assert property (
      !cfg[c].enh_func[ENH_ON_BIT]
      |-> (cfg[c].int_enable & IE_ENH_MASK) == 8'h0000 && cfg[c].div_frac == 8'h0000)
      else $error("extended bits active without enhanced bit");
    a_load_one_pulse: assert property (
      evt[c].tx_load |=> !evt[c].tx_load)
      else $error("transmit load pulse longer than one cycle");
  end
endmodule : duart_decode_sva

bind duart_register_decode_loopback duart_decode_sva u_sva (
  .clk           (clk),
  .reset_n       (reset_n),
  .host_pins     (host_pins),
  .host_rdata    (host_rdata),
  .host_rdata_oe (host_rdata_oe),
  .tx_pin        (tx_pin),
  .rts_n_pin     (rts_n_pin),
  .tx_shift_out  (tx_shift_out),
  .core_in       (core_in),
  .cfg           (cfg),
  .evt           (evt)
);

`default_nettype wire

// file: verification/duart_far_end.sv
// far-end model: serial pins and channel core as seen by the decoder
`timescale 1ns/100ps
`default_nettype none

module duart_far_end
  import duart_regs_pkg::*;
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // drive modem inputs active (low)
  input  wire logic             modem_act,
  // pins and core side
  output var serial_in_t        line_pins [NUM_CH],
  output logic [NUM_CH-1:0]     tx_shift_out,
  output var chan_stat_t        stat      [NUM_CH]
);
  // keeps both shifter outputs moving so a stuck loopback path shows up
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift_out <= '1;
    end else begin
      tx_shift_out <= {tx_shift_out[0], ~tx_shift_out[1]};
    end
  end

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      line_pins[c] = {1'b1, {4{~modem_act}}};
      stat[c] = '{8'h00C0 + 8'(c), 8'h00F1, 8'h0060, 8'h00B0 + 8'(c)};
    end
  end
endmodule : duart_far_end

`default_nettype wire

// file: verification/duart_register_decode_loopback_tb.sv
// self-checking bench: register map, channel split and loopback routing
`timescale 1ns/100ps
`default_nettype none

module duart_register_decode_loopback_tb
  import duart_regs_pkg::*;
;
  localparam logic [7:0] REV_VALUE = 8'h0021; // arbitrary value
  localparam logic [7:0] IDV_VALUE = 8'h0043; // arbitrary value

  logic              clk;
  logic              reset_n;
  host_bus_t         pins;
  logic              modem_act;
  logic [7:0]        host_rdata;
  logic              host_rdata_oe;
  serial_in_t        line_pins [NUM_CH];
  logic [NUM_CH-1:0] tx_pin;
  logic [NUM_CH-1:0] rts_n_pin;
  logic [NUM_CH-1:0] dtr_n_pin;
  logic [NUM_CH-1:0] tx_shift_out;
  chan_stat_t        stat      [NUM_CH];
  serial_in_t        core_in   [NUM_CH];
  chan_cfg_t         cfg       [NUM_CH];
  chan_evt_t         evt       [NUM_CH];
  logic [7:0]        tx_seen;
  int                n_errors;
  int                checked;

  duart_register_decode_loopback #(
    .REVISION_CODE (REV_VALUE),
    .IDENT_CODE    (IDV_VALUE)
  ) DUT (
    .clk           (clk),
    .reset_n       (reset_n),
    .host_pins     (pins),
    .host_rdata    (host_rdata),
    .host_rdata_oe (host_rdata_oe),
    .line_pins     (line_pins),
    .tx_pin        (tx_pin),
    .rts_n_pin     (rts_n_pin),
    .dtr_n_pin     (dtr_n_pin),
    .tx_shift_out  (tx_shift_out),
    .stat          (stat),
    .core_in       (core_in),
    .cfg           (cfg),
    .evt           (evt)
  );

  duart_far_end FE (
    .clk          (clk),
    .reset_n      (reset_n),
    .modem_act    (modem_act),
    .line_pins    (line_pins),
    .tx_shift_out (tx_shift_out),
    .stat         (stat)
  );

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (evt[0].tx_load === 1'b1) begin
      tx_seen <= evt[0].data;
    end
  end

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8

  // strobes are synchronised inside, so every phase is held well past the filter
  task automatic bus_wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    pins.sel_a_n <= ch;
    pins.sel_b_n <= ~ch;
    pins.addr    <= a;
    pins.wdata   <= d;
    pins.wr_n    <= 1'b0;
    repeat (5) @(posedge clk);
    pins.wr_n <= 1'b1;
    repeat (8) @(posedge clk);
    pins <= BUS_IDLE;
    repeat (4) @(negedge clk);
  endtask : bus_wr

  task automatic expect_rd(input logic ch, input logic [2:0] a, input logic [7:0] exp);
    int n;
    logic [7:0] d;
    @(posedge clk);
    pins.sel_a_n <= ch;
    pins.sel_b_n <= ~ch;
    pins.addr    <= a;
    pins.rd_n    <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (host_rdata_oe !== 1'b1 && n < 16);
    d = (host_rdata_oe === 1'b1) ? host_rdata : 8'hxx;
    @(posedge clk);
    pins.rd_n <= 1'b1;
    repeat (8) @(posedge clk);
    pins <= BUS_IDLE;
    repeat (4) @(negedge clk);
    check8(d, exp);
  endtask : expect_rd

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    clk       = 1'b0;
    reset_n   = 1'b0;
    pins      = BUS_IDLE;
    modem_act = 1'b0;
    n_errors  = 0;
    checked   = 0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    expect_rd(1'b0, ADDR_LINE, 8'h0000);
    bus_wr(1'b0, ADDR_SCRATCH, 8'h00A5);
    bus_wr(1'b1, ADDR_SCRATCH, 8'h003C);
    expect_rd(1'b0, ADDR_SCRATCH, 8'h00A5);
    expect_rd(1'b1, ADDR_SCRATCH, 8'h003C);
    bus_wr(1'b0, ADDR_IE, 8'h00F5);
    check8(cfg[0].int_enable, 8'h0005);
    check8(cfg[1].int_enable, 8'h0000);
    expect_rd(1'b0, ADDR_HOLDING, 8'h00C0);
    bus_wr(1'b0, ADDR_HOLDING, 8'h0055);
    check8(tx_seen, 8'h0055);
    expect_rd(1'b0, ADDR_STATUS, 8'h00C1);
    bus_wr(1'b0, ADDR_LSTAT, 8'h00FF);
    expect_rd(1'b0, ADDR_LSTAT, 8'h0060);
    expect_rd(1'b0, ADDR_MSTAT, 8'h00B0);
    expect_rd(1'b0, ADDR_SCRATCH, 8'h00A5);
    bus_wr(1'b0, ADDR_LINE, 8'h0080);
    expect_rd(1'b0, ADDR_HOLDING, REV_VALUE);
    expect_rd(1'b0, ADDR_IE, IDV_VALUE);
    bus_wr(1'b0, ADDR_IE, 8'h0012);
    expect_rd(1'b0, ADDR_IE, 8'h0012);
    expect_rd(1'b0, ADDR_HOLDING, 8'h0000);
    bus_wr(1'b0, ADDR_STATUS, 8'h00FF);
    check8(cfg[0].div_frac, 8'h0000);
    check8(evt[0].data, 8'h00CF);
    bus_wr(1'b0, ADDR_LINE, LINE_KEY);
    bus_wr(1'b0, ADDR_STATUS, 8'h0010);
    expect_rd(1'b0, ADDR_STATUS, 8'h0010);
    for (int i = 4; i < 8; i++) begin
      bus_wr(1'b0, 3'(i), 8'h0070 + 8'(i));
      expect_rd(1'b0, 3'(i), 8'h0070 + 8'(i));
    end
    check8(cfg[0].xoff2, 8'h0077);
    check8(cfg[0].modem_ctl, 8'h0000);
    expect_rd(1'b0, ADDR_LINE, LINE_KEY);
    bus_wr(1'b0, ADDR_LINE, 8'h0080);
    bus_wr(1'b0, ADDR_STATUS, 8'h00FF);
    expect_rd(1'b0, ADDR_STATUS, 8'h003F);
    check8(cfg[0].div_frac, 8'h003F);
    bus_wr(1'b0, ADDR_LINE, 8'h0000);
    expect_rd(1'b0, ADDR_STATUS, 8'h00F1);
    expect_rd(1'b1, ADDR_STATUS, 8'h00C1);
    bus_wr(1'b0, ADDR_MODEM, 8'h0003);
    check8({7'h00, rts_n_pin[0]}, 8'h0000);
    check8({7'h00, dtr_n_pin[0]}, 8'h0000);
    modem_act <= 1'b1;
    bus_wr(1'b0, ADDR_MODEM, 8'h0010);
    check8({7'h00, cfg[0].loopback}, 8'h0001);
    check8({7'h00, rts_n_pin[0]}, 8'h0000);
    check8({7'h00, dtr_n_pin[0]}, 8'h0000);
    check8({4'h0, core_in[0][3:0]}, 8'h000F);
    check8({7'h00, core_in[0].rx ^ tx_shift_out[0]}, 8'h0000);
    check8({3'h0, core_in[1]}, 8'h0010);
    expect_rd(1'b0, ADDR_SCRATCH, 8'h00A5);
    bus_wr(1'b0, ADDR_MODEM, 8'h0000);
    check8({7'h00, cfg[0].loopback}, 8'h0000);
    check8({7'h00, rts_n_pin[0]}, 8'h0001);
    check8({7'h00, dtr_n_pin[0]}, 8'h0001);
    @(posedge clk);
    pins.sel_a_n <= 1'b0;
    pins.sel_b_n <= 1'b0;
    pins.rd_n    <= 1'b0;
    repeat (12) @(negedge clk);
    check8({7'h00, host_rdata_oe}, 8'h0000);
    @(posedge clk);
    pins <= BUS_IDLE;
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : duart_register_decode_loopback_tb

`default_nettype wire
